// ---- rtl/occ_pkg.sv ----
// Constants for the channel offset calibration and chop select block
//
// Behaviour
// - Offset and gain trims are adjustable only in serial register mode, never in pin mode.
// - After reset the modulator chops at the modulator clock divided by 32.
// - In pin mode the chop rate is fixed at the modulator clock divided by 32.
// - In serial register mode software picks a chop divisor of 32 or 8, and the block applies it.
// - Each channel holds a signed 24-bit offset split over high, middle and low byte registers.
// - At nominal gain one offset step moves the output by minus four thirds of an output LSB.
// - Offset is subtracted before gain is applied, so the step size scales with the gain.
// - Reset restores every channel's offset registers to the factory value.
// - Each channel holds a three-byte gain coefficient that software may overwrite and reset restores.
package occ_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the control port)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CHOP_CFG   = 8'h00; // Bit 0: 1 selects divide by 8
  localparam logic [7:0] ADDR_STATUS     = 8'h01; // Bit 0: pin mode, bit 1: fast chop active
  localparam logic [7:0] ADDR_CH_BASE    = 8'h40; // First channel block
  localparam int         CH_STRIDE_LOG2  = 3;     // Eight bytes per channel block
  localparam logic [2:0] SUB_GAIN_HIGH   = 3'h0;
  localparam logic [2:0] SUB_GAIN_MIDDLE = 3'h1;
  localparam logic [2:0] SUB_GAIN_LOW    = 3'h2;
  localparam logic [2:0] SUB_OFF_HIGH    = 3'h3;
  localparam logic [2:0] SUB_OFF_MIDDLE  = 3'h4;
  localparam logic [2:0] SUB_OFF_LOW     = 3'h5;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          CHOP_SEL_BIT      = 0;
  localparam int          STAT_PIN_BIT      = 1 - 1;
  localparam int          STAT_FAST_BIT     = 1;
  localparam logic        CHOP_SEL_RESET    = 1'b0;
  localparam logic [23:0] FACTORY_OFFSET    = 24'h000000;
  localparam logic [23:0] FACTORY_GAIN      = 24'h555555;

  // ---------------------------------------------------------------
  // Chop divisors and datapath scaling
  // ---------------------------------------------------------------
  localparam int          CHOP_DIV_SLOW     = 32;
  localparam int          CHOP_DIV_FAST     = 8;
  localparam int          GAIN_SHIFT        = 22; // Nominal gain over 2^22 gives 4/3
  localparam int          DATA_W            = 24;

endpackage

// ---- rtl/occ_chop_div.sv ----
// Chop clock divider counting modulator clock enables
module occ_chop_div #(
  parameter int CNT_W = 5
) (
  input  wire logic             clk_i,      // System clock
  input  wire logic             resetn_i,   // Async reset, active low
  input  wire logic             tick_i,     // One pulse per modulator clock
  input  wire logic [CNT_W-1:0] half_i,     // Half period minus one, in ticks
  output logic                  chop_o,     // Chop phase level
  output logic                  edge_o      // Pulse when the phase flips
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             ph_r;
  logic             ph_nxt;
  logic             edge_nxt;
  logic             edge_r;

  // Next count; a shorter half period takes effect at once via >=
  always_comb begin
    cnt_nxt  = cnt_r;
    ph_nxt   = ph_r;
    edge_nxt = 1'b0;
    if (tick_i) begin
      if (cnt_r >= half_i) begin
        cnt_nxt  = '0;
        ph_nxt   = ~ph_r;
        edge_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r  <= '0;
      ph_r   <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      ph_r   <= ph_nxt;
      edge_r <= edge_nxt;
    end
  end

  assign chop_o = ph_r;
  assign edge_o = edge_r;

endmodule

// ---- rtl/occ_top.sv ----
// Per-channel offset and gain calibration with modulator chop rate select
module occ_top
  import occ_pkg::*;
#(
  parameter int NCH = 8,          // Number of channels
  parameter int CHW = 3           // Channel index width
) (
  input  wire logic                       clk_i,          // Master clock, 100 MHz
  input  wire logic                       resetn_i,       // Async reset, active low
  input  wire logic                       pin_mode_i,     // High: pin control mode
  input  wire logic                       mod_tick_i,     // One pulse per modulator clock
  input  wire logic                       reg_wr_i,       // Register write strobe
  input  wire logic                       reg_rd_i,       // Register read strobe
  input  wire logic [7:0]                 reg_addr_i,     // Register byte address
  input  wire logic [7:0]                 reg_wdata_i,    // Register write data
  output logic      [7:0]                 reg_rdata_o,    // Register read data
  input  wire logic                       smp_valid_i,    // Raw sample strobe
  input  wire logic [CHW-1:0]             smp_ch_i,       // Raw sample channel
  input  wire logic [occ_pkg::DATA_W-1:0] smp_data_i,     // Raw sample, two's complement
  output logic                            out_valid_o,    // Corrected sample strobe
  output logic      [CHW-1:0]             out_ch_o,       // Corrected sample channel
  output logic      [occ_pkg::DATA_W-1:0] out_data_o,     // Corrected sample
  output logic                            chop_o,         // Modulator chop phase
  output logic                            chop_edge_o     // Pulse on each chop flip
);
  import occ_pkg::*;

  // Divider half periods minus one, in ticks, and the output saturation limits
  localparam logic [4:0] HALF_SLOW = 5'(CHOP_DIV_SLOW / 2 - 1);
  localparam logic [4:0] HALF_FAST = 5'(CHOP_DIV_FAST / 2 - 1);
  localparam int         PW        = 2 * DATA_W + 2;
  localparam logic signed [PW-1:0] SAT_MAX = PW'(2 ** (DATA_W - 1) - 1);
  localparam logic signed [PW-1:0] SAT_MIN = -PW'(2 ** (DATA_W - 1));

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] off_r   [NCH];
  logic [DATA_W-1:0] off_nxt [NCH];
  logic [DATA_W-1:0] gain_r  [NCH];
  logic [DATA_W-1:0] gain_nxt[NCH];
  logic              chop_sel_r;
  logic              chop_sel_nxt;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;
  logic              in_ch_blk;
  logic [CHW-1:0]    ch_idx;
  logic [2:0]        sub_idx;
  logic              fast_chop;

  // Channel block decode; addresses past the last channel are unmapped
  always_comb begin
    in_ch_blk = (reg_addr_i >= ADDR_CH_BASE) &&
                ((reg_addr_i - ADDR_CH_BASE) < 8'(NCH << CH_STRIDE_LOG2));
    ch_idx    = CHW'((reg_addr_i - ADDR_CH_BASE) >> CH_STRIDE_LOG2);
    sub_idx   = reg_addr_i[2:0];
  end

  // Fast chop only counts in register mode; pin mode pins it to /32
  // pin mode fixed
  assign fast_chop = chop_sel_r && !pin_mode_i;

  // Write side: pin mode leaves no calibration or chop setting writable
  always_comb begin
    off_nxt      = off_r;
    gain_nxt     = gain_r;
    chop_sel_nxt = chop_sel_r;
    if (reg_wr_i && !pin_mode_i) begin
      if (reg_addr_i == ADDR_CHOP_CFG) begin
        chop_sel_nxt = reg_wdata_i[CHOP_SEL_BIT];
      end else if (in_ch_blk) begin
        unique case (sub_idx)
          SUB_GAIN_HIGH:   gain_nxt[ch_idx][23:16] = reg_wdata_i;
          SUB_GAIN_MIDDLE: gain_nxt[ch_idx][15:8]  = reg_wdata_i;
          SUB_GAIN_LOW:    gain_nxt[ch_idx][7:0]   = reg_wdata_i;
          SUB_OFF_HIGH:    off_nxt[ch_idx][23:16]  = reg_wdata_i;
          SUB_OFF_MIDDLE:  off_nxt[ch_idx][15:8]   = reg_wdata_i;
          SUB_OFF_LOW:     off_nxt[ch_idx][7:0]    = reg_wdata_i;
          default:         ;
        endcase
      end
    end
  end

  // Read side; unmapped and reserved bytes read as zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_i) begin
      rdata_nxt = 8'h00;
      if (reg_addr_i == ADDR_CHOP_CFG) begin
        rdata_nxt[CHOP_SEL_BIT] = chop_sel_r;
      end else if (reg_addr_i == ADDR_STATUS) begin
        rdata_nxt[STAT_PIN_BIT]  = pin_mode_i;
        rdata_nxt[STAT_FAST_BIT] = fast_chop;
      end else if (in_ch_blk) begin
        unique case (sub_idx)
          SUB_GAIN_HIGH:   rdata_nxt = gain_r[ch_idx][23:16];
          SUB_GAIN_MIDDLE: rdata_nxt = gain_r[ch_idx][15:8];
          SUB_GAIN_LOW:    rdata_nxt = gain_r[ch_idx][7:0];
          SUB_OFF_HIGH:    rdata_nxt = off_r[ch_idx][23:16];
          SUB_OFF_MIDDLE:  rdata_nxt = off_r[ch_idx][15:8];
          SUB_OFF_LOW:     rdata_nxt = off_r[ch_idx][7:0];
          default:         rdata_nxt = 8'h00;
        endcase
      end
    end
  end

  // Register storage; reset brings back factory trims and /32 chop
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NCH; i++) begin
        off_r[i]  <= FACTORY_OFFSET;
        gain_r[i] <= FACTORY_GAIN;
      end
      chop_sel_r <= CHOP_SEL_RESET;
      rdata_r    <= 8'h00;
    end else begin
      off_r      <= off_nxt;
      gain_r     <= gain_nxt;
      chop_sel_r <= chop_sel_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // Read data stays put until the next read strobe
  assign reg_rdata_o = rdata_r;

  // ---------------------------------------------------------------
  // Chop divider
  // ---------------------------------------------------------------
  // Half period minus one, in ticks; pin mode overrides the stored select
  logic [4:0] chop_half;

  assign chop_half = fast_chop ? HALF_FAST : HALF_SLOW;

  occ_chop_div #(
    .CNT_W (5)
  ) u_chop (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .tick_i   (mod_tick_i),
    .half_i   (chop_half),
    .chop_o   (chop_o),
    .edge_o   (chop_edge_o)
  );

  // ---------------------------------------------------------------
  // Correction datapath
  // ---------------------------------------------------------------
  logic signed [DATA_W:0]   diff;
  logic signed [PW-1:0]     prod;
  logic signed [PW-1:0]     scaled;
  logic        [DATA_W-1:0] eff_off;
  logic        [DATA_W-1:0] eff_gain;
  logic        [DATA_W-1:0] sat_val;
  logic        [DATA_W-1:0] res_nxt;
  logic        [DATA_W-1:0] res_r;
  logic                     vld_nxt;
  logic                     vld_r;
  logic        [CHW-1:0]    ch_nxt;
  logic        [CHW-1:0]    ch_r;

  // Pin mode ignores stored trims; the product is wide enough that
  // a full-scale sample at maximum gain cannot wrap before saturation
  always_comb begin
    eff_off  = pin_mode_i ? FACTORY_OFFSET : off_r[smp_ch_i];
    eff_gain = pin_mode_i ? FACTORY_GAIN   : gain_r[smp_ch_i];
    diff     = $signed({smp_data_i[DATA_W-1], smp_data_i}) - $signed({eff_off[DATA_W-1], eff_off});
    prod     = PW'(diff) * $signed(PW'({1'b0, eff_gain}));
    // nominal gain gives -4/3 per step
    scaled   = prod >>> GAIN_SHIFT;
    if (scaled > SAT_MAX) begin
      sat_val = SAT_MAX[DATA_W-1:0];
    end else if (scaled < SAT_MIN) begin
      sat_val = SAT_MIN[DATA_W-1:0];
    end else begin
      sat_val = scaled[DATA_W-1:0];
    end
  end

  // Output next state; word and channel hold between samples so a slow
  // reader never sees a half-updated pair, at the cost of one cycle of latency
  always_comb begin
    vld_nxt = smp_valid_i;
    ch_nxt  = ch_r;
    res_nxt = res_r;
    if (smp_valid_i) begin
      ch_nxt  = smp_ch_i;
      res_nxt = sat_val;
    end
  end

  // Output registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_r <= '0;
      ch_r  <= '0;
      vld_r <= 1'b0;
    end else begin
      res_r <= res_nxt;
      ch_r  <= ch_nxt;
      vld_r <= vld_nxt;
    end
  end

  // Corrected sample outputs come straight from flip-flops
  assign out_valid_o = vld_r;
  assign out_ch_o    = ch_r;
  assign out_data_o  = res_r;

endmodule

// ---- dv/occ_assertions.sv ----
// Port-level assertions for the offset calibration and chop select block
module occ_assertions
  import occ_pkg::*;
#(
  parameter int CHW = 3
) (
  input wire logic           clk_i,       // Master clock
  input wire logic           resetn_i,    // Async reset, active low
  input wire logic           pin_mode_i,  // Pin control mode
  input wire logic           mod_tick_i,  // Modulator tick
  input wire logic           reg_wr_i,    // Write strobe
  input wire logic           reg_rd_i,    // Read strobe
  input wire logic [7:0]     reg_addr_i,  // Address
  input wire logic [7:0]     reg_wdata_i, // Write data
  input wire logic [7:0]     reg_rdata_o, // Read data
  input wire logic           smp_valid_i, // Raw strobe
  input wire logic [CHW-1:0] smp_ch_i,    // Raw channel
  input wire logic           out_valid_o, // Corrected strobe
  input wire logic [CHW-1:0] out_ch_o,    // Corrected channel
  input wire logic [23:0]    out_data_o,  // Corrected sample
  input wire logic           chop_o,      // Chop phase
  input wire logic           chop_edge_o  // Chop flip pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [4:0] tcnt_r, tcnt_nxt, hl_r, hl_nxt, half_w;
  logic       ok_r, ok_nxt, sel_r, sel_nxt, unm_w;

  // Expected half period; a divisor change mid-period leaves that period unchecked
  assign half_w = (pin_mode_i || !sel_r) ? 5'h10 : 5'h04;
  assign unm_w  = (reg_addr_i > 8'h01 && reg_addr_i < ADDR_CH_BASE) || reg_addr_i[7] || reg_addr_i[2:1] == 2'b11;
  // Tick count since the last chop flip and the shadow divisor select
  always_comb begin
    sel_nxt = sel_r;
    if (reg_wr_i && !pin_mode_i && reg_addr_i == ADDR_CHOP_CFG) begin
      sel_nxt = reg_wdata_i[CHOP_SEL_BIT];
    end
    tcnt_nxt = chop_edge_o ? 5'(mod_tick_i) : tcnt_r + 5'(mod_tick_i);
    hl_nxt   = chop_edge_o ? half_w : hl_r;
    ok_nxt   = chop_edge_o || (ok_r && half_w == hl_r);
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tcnt_r <= 5'h00;
      hl_r   <= 5'h10;
      ok_r   <= 1'b1;
      sel_r  <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt;
      hl_r   <= hl_nxt;
      ok_r   <= ok_nxt;
      sel_r  <= sel_nxt;
    end
  end

  chk_out_latency: assert property (1'b1 |=> out_valid_o == $past(smp_valid_i))
    else $error("corrected strobe not one cycle after raw strobe");
  chk_out_chan: assert property (smp_valid_i |=> out_ch_o == $past(smp_ch_i))
    else $error("corrected channel differs from raw channel");
  chk_out_hold: assert property (!smp_valid_i |=> $stable(out_data_o) && $stable(out_ch_o))
    else $error("corrected sample changed without a raw sample");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  chk_unmapped_zero: assert property (reg_rd_i && unm_w |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_status_pin: assert property (reg_rd_i && reg_addr_i == ADDR_STATUS |=> reg_rdata_o[STAT_PIN_BIT] == $past(pin_mode_i))
    else $error("status mode bit wrong");
  chk_edge_pair: assert property (chop_edge_o == $changed(chop_o))
    else $error("chop pulse and phase change disagree");
  chk_chop_cause: assert property ($changed(chop_o) |-> $past(mod_tick_i))
    else $error("chop flipped without a tick");
  chk_chop_period: assert property (chop_edge_o && ok_r |-> tcnt_r == hl_r)
    else $error("chop half period wrong");

  cover property (reg_rd_i && reg_addr_i == ADDR_STATUS && pin_mode_i);
  cover property (chop_edge_o && ok_r && hl_r == 5'h04);
  cover property (chop_edge_o && ok_r && pin_mode_i);
  cover property (out_valid_o);
endmodule

bind occ_top occ_assertions #(.CHW(CHW)) chk_u (.clk_i, .resetn_i, .pin_mode_i, .mod_tick_i, .reg_wr_i, .reg_rd_i,
  .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .smp_valid_i, .smp_ch_i, .out_valid_o, .out_ch_o, .out_data_o, .chop_o,
  .chop_edge_o);

// ---- dv/occ_top_tb_top.sv ----
// Self-checking bench for the offset calibration and chop select block
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("wrong value at %0t: %h not %h", $time, g, e); end end
module occ_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import occ_pkg::*;
  logic        clk_i, resetn_i, pin_mode_i, mod_tick_i, reg_wr_i, reg_rd_i, smp_valid_i;
  logic        out_valid_o, chop_o, chop_edge_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [2:0]  smp_ch_i, out_ch_o;
  logic [23:0] smp_data_i, out_data_o;
  int          fails = 0, n_checks = 0, edges;

  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  occ_top #(.NCH(8), .CHW(3)) dut_u (.clk_i, .resetn_i, .pin_mode_i, .mod_tick_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rdata_o, .smp_valid_i, .smp_ch_i, .smp_data_i, .out_valid_o, .out_ch_o, .out_data_o, .chop_o,
    .chop_edge_o);

  // Reset held for eight cycles
  task automatic rst;
    @(posedge clk_i);
    resetn_i <= 0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 0;
  endtask
  // Read data is settled one cycle after the read edge
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_i);
    reg_rd_i <= 1; reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 0;
    #1 `CK(reg_rdata_o, e)
  endtask
  // Expected value uses floor shift and saturation, worked out here independently
  task automatic smp(input logic [2:0] c, input logic [23:0] x, off, g);
    longint v;
    v = ((longint'($signed(x)) - longint'($signed(off))) * longint'(g)) >>> 22;
    if (v > 64'sh7fffff) v = 64'sh7fffff;
    else if (v < -64'sh800000) v = -64'sh800000;
    @(posedge clk_i);
    smp_valid_i <= 1; smp_ch_i <= c; smp_data_i <= x;
    @(posedge clk_i);
    smp_valid_i <= 0;
    #1 `CK(out_valid_o, 1'b1)
    `CK(out_data_o, v[23:0])
    `CK(out_ch_o, c)
  endtask
  // Ticks every other cycle, counting chop flip pulses
  task automatic ticks(input int n, e);
    edges = 0;
    repeat (n) begin
      @(posedge clk_i);
      mod_tick_i <= 1;
      @(posedge clk_i);
      mod_tick_i <= 0;
      #1 edges += chop_edge_o;
    end
    `CK(edges, e)
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    resetn_i = 0; pin_mode_i = 0; mod_tick_i = 0; reg_wr_i = 0; reg_rd_i = 0; reg_addr_i = 0;
    reg_wdata_i = 0; smp_valid_i = 0; smp_ch_i = 0; smp_data_i = 0;
    rst();
    // Factory image of all channel blocks, reserved and unmapped places
    for (int i = 0; i < 64; i++) rd(ADDR_CH_BASE + 8'(i), (i % 8) < 3 ? 8'h55 : 8'h00);
    rd(ADDR_CHOP_CFG, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h80, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    // Offset 100 on channel 3 written byte by byte
    wr(8'h5b, 8'h00); wr(8'h5c, 8'h00); wr(8'h5d, 8'h64);
    rd(8'h5d, 8'h64);
    smp(3, 24'h000000, 24'h000064, FACTORY_GAIN);
    smp(2, 24'h000000, 24'h000000, FACTORY_GAIN);
    wr(8'h58, 8'h2a); wr(8'h59, 8'haa); wr(8'h5a, 8'haa);
    smp(3, 24'h001000, 24'h000064, 24'h2aaaaa);
    wr(8'h5b, 8'h80); wr(8'h5d, 8'h00);
    smp(3, 24'h7fffff, 24'h800000, 24'h2aaaaa);
    // Pin mode refuses writes and falls back to factory trims and slow chop
    @(posedge clk_i);
    pin_mode_i <= 1;
    wr(8'h5d, 8'h11); wr(ADDR_CHOP_CFG, 8'h01);
    rd(8'h5d, 8'h00);
    rd(ADDR_CHOP_CFG, 8'h00);
    rd(ADDR_STATUS, 8'h01);
    smp(3, 24'h000300, FACTORY_OFFSET, FACTORY_GAIN);
    ticks(64, 4);
    // Second reset restores trims; fast chop then selected
    @(posedge clk_i);
    pin_mode_i <= 0;
    rst();
    rd(8'h5b, 8'h00);
    rd(8'h58, 8'h55);
    ticks(32, 2);
    wr(ADDR_CHOP_CFG, 8'h01);
    rd(ADDR_CHOP_CFG, 8'h01);
    rd(ADDR_STATUS, 8'h02);
    ticks(64, 16);
    @(posedge clk_i);
    pin_mode_i <= 1;
    ticks(64, 4);
    rd(ADDR_STATUS, 8'h01);
    print_verdict();
  end
endmodule
